//--- pca_map.svh
`ifndef PCA_MAP_SVH
`define PCA_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define PCA_LO_DATA_OFS   12'h5d0
`define PCA_LO_CTL_OFS    12'h5d4
`define PCA_HI_DATA_OFS   12'h5d8
`define PCA_HI_CTL_OFS    12'h5dc
`define PCA_IRQ_STAT_OFS  12'h5e0
`define PCA_IRQ_MASK_OFS  12'h5e4

// ==========================================================
// field positions
`define PCA_DATA_HI       31
`define PCA_DATA_LO       16
`define PCA_ADDR_HI       15
`define PCA_ADDR_LO       0
`define PCA_CTL_RSV_HI    31
`define PCA_CTL_RSV_LO    7
`define PCA_CTL_RST_BIT   6
`define PCA_CTL_ST_HI     5
`define PCA_CTL_ST_LO     3
`define PCA_CTL_DONE_BIT  2
`define PCA_CTL_DIS_BIT   1
`define PCA_CTL_DIR_BIT   0

// ==========================================================
// reset values
`define PCA_DATA_RST      32'h0000_0000
`define PCA_CTL_RST       32'h0000_0000
`define PCA_IRQ_RST       2'h0

`endif

//--- pca_pkg.sv
package pca_pkg;

  // ==========================================================
  // access engine state, visible in the control register
  typedef enum logic [2:0] {
    PCA_ST_IDLE = 3'b000,
    PCA_ST_REQ  = 3'b001,
    PCA_ST_FIN  = 3'b010
  } pca_state_t;

  typedef struct packed {
    pca_state_t  state;
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        fin_rd;
  } pca_eng_t;

  typedef struct packed {
    logic [31:0] data;
    logic [24:0] rsv;
    logic        rst;
    logic        done;
    logic        dis;
    logic        dir;
  } pca_grp_t;

  typedef struct packed {
    pca_grp_t [1:0] grp;
    logic [31:0]    rdata;
  } pca_top_t;

  typedef struct packed {
    logic [1:0] stat;
    logic [1:0] mask;
    logic       irq;
  } pca_irq_t;

endpackage : pca_pkg

//--- pca_engine.sv
`timescale 1ns/1ps
`default_nettype none

module pca_engine (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         soft_rst,
  input  wire logic         launch,
  input  wire logic         dir,
  input  wire logic [15:0]  addr,
  input  wire logic [15:0]  wdata,
  input  wire logic         phy_ack,
  input  wire logic [15:0]  phy_rdata,
  output logic              phy_req,
  output logic              phy_we,
  output logic [15:0]       phy_addr,
  output logic [15:0]       phy_wdata,
  output logic [2:0]        state,
  output logic              fin,
  output logic              fin_rd,
  output logic [15:0]       rdata
);

  pca_pkg::pca_eng_t s_r;
  pca_pkg::pca_eng_t s_nxt;

  // ==========================================================
  // one access: request held until the phy acknowledges or a soft reset drops it
  always_comb begin
    s_nxt = s_r;
    if (soft_rst) begin
      s_nxt.state = pca_pkg::PCA_ST_IDLE;
      s_nxt.req   = 1'b0;
    end else begin
      case (s_r.state)
        pca_pkg::PCA_ST_IDLE: begin
          if (launch) begin
            s_nxt.state = pca_pkg::PCA_ST_REQ;
            s_nxt.req   = 1'b1;
            s_nxt.we    = dir;
            s_nxt.addr  = addr;
            s_nxt.wdata = wdata;
          end
        end
        pca_pkg::PCA_ST_REQ: begin
          if (phy_ack) begin
            s_nxt.state  = pca_pkg::PCA_ST_FIN;
            s_nxt.req    = 1'b0;
            s_nxt.fin_rd = ~s_r.we;
            if (!s_r.we) begin
              s_nxt.rdata = phy_rdata;
            end
          end
        end
        pca_pkg::PCA_ST_FIN: begin
          s_nxt.state = pca_pkg::PCA_ST_IDLE;
        end
        default: begin
          s_nxt.state = pca_pkg::PCA_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign phy_req   = s_r.req;
  assign phy_we    = s_r.we;
  assign phy_addr  = s_r.addr;
  assign phy_wdata = s_r.wdata;
  assign state     = s_r.state;
  assign fin       = (s_r.state == pca_pkg::PCA_ST_FIN);
  assign fin_rd    = fin & s_r.fin_rd;
  assign rdata     = s_r.rdata;

endmodule : pca_engine

`default_nettype wire

//--- pca_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "pca_map.svh"

module pca_irq (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [1:0]  evt,
  input  wire logic        wr_stat,
  input  wire logic        wr_mask,
  input  wire logic [1:0]  wdata,
  output logic [1:0]       stat,
  output logic [1:0]       mask,
  output logic             irq
);

  pca_pkg::pca_irq_t s_r;
  pca_pkg::pca_irq_t s_nxt;

  // ==========================================================
  // sticky status, write one to clear, set beats clear
  always_comb begin
    s_nxt = s_r;
    if (wr_stat) begin
      s_nxt.stat = s_r.stat & ~wdata;
    end
    s_nxt.stat = s_nxt.stat | evt;
    if (wr_mask) begin
      s_nxt.mask = wdata;
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= {`PCA_IRQ_RST, `PCA_IRQ_RST, 1'b0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign stat = s_r.stat;
  assign mask = s_r.mask;
  assign irq  = s_r.irq;

endmodule : pca_irq

`default_nettype wire

//--- pca_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pca_map.svh"

module pca_top (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [11:0]  bus_addr,
  input  wire logic [31:0]  bus_wdata,
  input  wire logic         bus_wr,
  input  wire logic         bus_rd,
  output logic [31:0]       bus_rdata,
  output logic              irq,
  output logic              phy_lo_req,
  output logic              phy_lo_we,
  output logic [15:0]       phy_lo_addr,
  output logic [15:0]       phy_lo_wdata,
  input  wire logic         phy_lo_ack,
  input  wire logic [15:0]  phy_lo_rdata,
  output logic              phy_hi_req,
  output logic              phy_hi_we,
  output logic [15:0]       phy_hi_addr,
  output logic [15:0]       phy_hi_wdata,
  input  wire logic         phy_hi_ack,
  input  wire logic [15:0]  phy_hi_rdata
);

  pca_pkg::pca_top_t s_r;
  pca_pkg::pca_top_t s_nxt;

  logic [1:0]        launch;
  logic [1:0]        eng_fin;
  logic [1:0]        eng_fin_rd;
  logic [2:0]        eng_state [1:0];
  logic [15:0]       eng_rdata [1:0];
  logic [1:0]        irq_stat;
  logic [1:0]        irq_mask;
  logic              wr_stat;
  logic              wr_mask;

  // ==========================================================
  // address decode per group
  function automatic logic [11:0] data_ofs(input int g);
    data_ofs = (g == 0) ? `PCA_LO_DATA_OFS : `PCA_HI_DATA_OFS;
  endfunction : data_ofs

  function automatic logic [11:0] ctl_ofs(input int g);
    ctl_ofs = (g == 0) ? `PCA_LO_CTL_OFS : `PCA_HI_CTL_OFS;
  endfunction : ctl_ofs

  assign wr_stat = bus_wr & (bus_addr == `PCA_IRQ_STAT_OFS);
  assign wr_mask = bus_wr & (bus_addr == `PCA_IRQ_MASK_OFS);

  // ==========================================================
  // register writes, launch and completion
  always_comb begin
    logic acc;
    logic wr_d;
    logic wr_c;
    acc    = 1'b0;
    wr_d   = 1'b0;
    wr_c   = 1'b0;
    s_nxt  = s_r;
    launch = 2'b00;
    for (int g = 0; g < 2; g++) begin
      wr_d = bus_wr & (bus_addr == data_ofs(g));
      wr_c = bus_wr & (bus_addr == ctl_ofs(g));
      acc  = (bus_wr | bus_rd) &
             ((bus_addr == data_ofs(g)) | (bus_addr == ctl_ofs(g)));
      if (wr_d) begin
        s_nxt.grp[g].data = bus_wdata;
      end
      if (wr_c) begin
        s_nxt.grp[g].rsv = bus_wdata[`PCA_CTL_RSV_HI:`PCA_CTL_RSV_LO];
        s_nxt.grp[g].rst = bus_wdata[`PCA_CTL_RST_BIT];
        s_nxt.grp[g].dis = bus_wdata[`PCA_CTL_DIS_BIT];
        s_nxt.grp[g].dir = bus_wdata[`PCA_CTL_DIR_BIT];
        if (!bus_wdata[`PCA_CTL_DONE_BIT]) begin
          s_nxt.grp[g].done = 1'b0;
        end
      end
      // launch uses the values as they stand after this write
      if (acc && !s_nxt.grp[g].dis && !s_nxt.grp[g].rst &&
          (eng_state[g] == pca_pkg::PCA_ST_IDLE)) begin
        launch[g]         = 1'b1;
        s_nxt.grp[g].done = 1'b0;
      end
      if (s_nxt.grp[g].rst) begin
        s_nxt.grp[g].done = 1'b0;
      end
      if (eng_fin_rd[g]) begin
        s_nxt.grp[g].data[`PCA_DATA_HI:`PCA_DATA_LO] = eng_rdata[g];
      end
      if (eng_fin[g]) begin
        s_nxt.grp[g].done = 1'b1;
      end
    end
    s_nxt.rdata = 32'h0000_0000;
    if (bus_rd) begin
      case (bus_addr)
        `PCA_LO_DATA_OFS: s_nxt.rdata = s_r.grp[0].data;
        `PCA_HI_DATA_OFS: s_nxt.rdata = s_r.grp[1].data;
        `PCA_LO_CTL_OFS: begin
          s_nxt.rdata = {s_r.grp[0].rsv,
                         s_r.grp[0].rst, eng_state[0], s_r.grp[0].done,
                         s_r.grp[0].dis, s_r.grp[0].dir};
        end
        `PCA_HI_CTL_OFS: begin
          s_nxt.rdata = {s_r.grp[1].rsv, s_r.grp[1].rst, eng_state[1],
                         s_r.grp[1].done, s_r.grp[1].dis,
                         s_r.grp[1].dir};
        end
        `PCA_IRQ_STAT_OFS: s_nxt.rdata = {30'h0, irq_stat};
        `PCA_IRQ_MASK_OFS: s_nxt.rdata = {30'h0, irq_mask};
        default:           s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= {{2{`PCA_DATA_RST, 25'h0, 4'h0}}, 32'h0000_0000};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign bus_rdata = s_r.rdata;

  // ==========================================================
  // access engines, lower and upper lanes
  pca_engine u_eng_lo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .ce        (ce),
    .soft_rst  (s_r.grp[0].rst & ~launch[0]),
    .launch    (launch[0]),
    .dir       (s_nxt.grp[0].dir),
    .addr      (s_nxt.grp[0].data[`PCA_ADDR_HI:`PCA_ADDR_LO]),
    .wdata     (s_nxt.grp[0].data[`PCA_DATA_HI:`PCA_DATA_LO]),
    .phy_ack   (phy_lo_ack),
    .phy_rdata (phy_lo_rdata),
    .phy_req   (phy_lo_req),
    .phy_we    (phy_lo_we),
    .phy_addr  (phy_lo_addr),
    .phy_wdata (phy_lo_wdata),
    .state     (eng_state[0]),
    .fin       (eng_fin[0]),
    .fin_rd    (eng_fin_rd[0]),
    .rdata     (eng_rdata[0])
  );

  pca_engine u_eng_hi (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .ce        (ce),
    .soft_rst  (s_r.grp[1].rst & ~launch[1]),
    .launch    (launch[1]),
    .dir       (s_nxt.grp[1].dir),
    .addr      (s_nxt.grp[1].data[`PCA_ADDR_HI:`PCA_ADDR_LO]),
    .wdata     (s_nxt.grp[1].data[`PCA_DATA_HI:`PCA_DATA_LO]),
    .phy_ack   (phy_hi_ack),
    .phy_rdata (phy_hi_rdata),
    .phy_req   (phy_hi_req),
    .phy_we    (phy_hi_we),
    .phy_addr  (phy_hi_addr),
    .phy_wdata (phy_hi_wdata),
    .state     (eng_state[1]),
    .fin       (eng_fin[1]),
    .fin_rd    (eng_fin_rd[1]),
    .rdata     (eng_rdata[1])
  );

  // ==========================================================
  // completion interrupt
  pca_irq u_irq (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ce      (ce),
    .evt     (eng_fin),
    .wr_stat (wr_stat),
    .wr_mask (wr_mask),
    .wdata   (bus_wdata[1:0]),
    .stat    (irq_stat),
    .mask    (irq_mask),
    .irq     (irq)
  );

endmodule : pca_top

`default_nettype wire

//--- pca_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pca_top_checker (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [11:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        irq,
  input wire logic        phy_lo_req,
  input wire logic        phy_lo_we,
  input wire logic [15:0] phy_lo_addr,
  input wire logic [15:0] phy_lo_wdata,
  input wire logic        phy_lo_ack,
  input wire logic        phy_hi_req,
  input wire logic        phy_hi_ack
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_rd; !$past(bus_rd) |-> bus_rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  property p_hold; phy_lo_req && $past(phy_lo_req) |->
    $stable({phy_lo_we, phy_lo_addr, phy_lo_wdata}); endproperty
  a_hold: assert property (p_hold) else $error("request fields moved");
  property p_lo_end; phy_lo_req && phy_lo_ack |=> !phy_lo_req [*2]; endproperty
  a_lo_end: assert property (p_lo_end) else $error("low request after ack");
  property p_hi_end; phy_hi_req && phy_hi_ack |=> !phy_hi_req [*2]; endproperty
  a_hi_end: assert property (p_hi_end) else $error("high request after ack");
  property p_lo_src; $rose(phy_lo_req) |->
    $past(bus_wr || bus_rd) && $past(bus_addr[11:3]) == 9'h0ba; endproperty
  a_lo_src: assert property (p_lo_src) else $error("low launch without access");
  property p_hi_src; $rose(phy_hi_req) |->
    $past(bus_wr || bus_rd) && $past(bus_addr[11:3]) == 9'h0bb; endproperty
  a_hi_src: assert property (p_hi_src) else $error("high launch without access");
  property p_dis; bus_wr && bus_addr == 12'h5d4 && bus_wdata[1] |=>
    !$rose(phy_lo_req); endproperty
  a_dis: assert property (p_dis) else $error("launch while disabled");
  property p_dir; $rose(phy_lo_req) && $past(bus_wr && bus_addr == 12'h5d4) |->
    phy_lo_we == $past(bus_wdata[0]); endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_wd; $rose(phy_lo_req) && $past(bus_wr && bus_addr == 12'h5d0) |->
    {phy_lo_wdata, phy_lo_addr} == $past(bus_wdata); endproperty
  a_wd: assert property (p_wd) else $error("wrong address or data");
  property p_irq; $rose(irq) |->
    $past(bus_wr) || $past(phy_lo_ack, 2) || $past(phy_hi_ack, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  c_lo: cover property ($rose(phy_lo_req));
  c_hi: cover property ($rose(phy_hi_req));
  c_irq: cover property ($rose(irq));
endmodule : pca_top_checker
bind pca_top pca_top_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
  .phy_lo_req(phy_lo_req), .phy_lo_we(phy_lo_we), .phy_lo_addr(phy_lo_addr),
  .phy_lo_wdata(phy_lo_wdata), .phy_lo_ack(phy_lo_ack), .phy_hi_req(phy_hi_req),
  .phy_hi_ack(phy_hi_ack));
`default_nettype wire

//--- pca_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module pca_phy_model (
  input wire logic        sys_clk,
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0]  lat,
  output var logic        ack,
  output var logic [15:0] rdata
);
  logic [15:0] mem [logic [15:0]];
  int          cnt = 0;
  initial begin
    ack = 1'b0;
    rdata = 16'h0;
  end
  // ==========================================================
  // answer after lat waits; data line garbled outside ack
  always @(posedge sys_clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack && cnt < lat) begin
      cnt <= cnt + 1;
    end else if (req && !ack) begin
      cnt <= 0;
      ack <= 1'b1;
      if (we) mem[addr] = wdata;
      rdata <= mem.exists(addr) ? mem[addr] : ~addr;
    end else begin
      cnt <= 0;
    end
  end
endmodule : pca_phy_model
`default_nettype wire

//--- phy_config_access_bench.sv
`timescale 1ns/1ps
`default_nettype none
module phy_config_access_bench;
  logic        sys_clk = 1'b0, nrst = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [11:0] bus_addr = 12'h0, b;
  logic [31:0] bus_wdata = 32'h0, bus_rdata, sd = 32'h993d26bb, v;
  logic        irq, lq, lw, la, hq, hw, ha;
  logic [15:0] lad, lwd, lrd, had, hwd, hrd;
  logic [1:0]  lat = 2'h0, stat = 2'h0, mask = 2'h0;
  logic [31:0] rg [4] = '{default: 32'h0};
  logic [15:0] pm [logic [15:0]];
  int          err_count = 0, compares = 0, i;
  always #25 sys_clk = ~sys_clk;
  pca_top dut (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
    .phy_lo_req(lq), .phy_lo_we(lw), .phy_lo_addr(lad), .phy_lo_wdata(lwd), .phy_lo_ack(la),
    .phy_lo_rdata(lrd), .phy_hi_req(hq), .phy_hi_we(hw), .phy_hi_addr(had),
    .phy_hi_wdata(hwd), .phy_hi_ack(ha), .phy_hi_rdata(hrd));
  pca_phy_model u_lo (.sys_clk(sys_clk), .req(lq), .we(lw), .addr(lad), .wdata(lwd),
    .lat(lat), .ack(la), .rdata(lrd));
  pca_phy_model u_hi (.sys_clk(sys_clk), .req(hq), .we(hw), .addr(had), .wdata(hwd),
    .lat(lat), .ack(ha), .rdata(hrd));
  function automatic logic [31:0] rnd();
    sd = sd ^ (sd << 13);
    sd = sd ^ (sd >> 17);
    sd = sd ^ (sd << 5);
    return sd;
  endfunction : rnd
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= w;
    bus_rd <= !w;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    #1 r = bus_rdata;
  endtask : bus
  // ==========================================================
  // one access plus model update; m 1 peeks while busy, m 2 aborts
  task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d, input int m);
    logic [31:0] e, r;
    logic [1:0]  k, ci, di;
    logic        g, go;
    int          n;
    g = a[3];
    k = a[3:2];
    ci = {g, 1'b1};
    di = {g, 1'b0};
    e = a[11:4] == 8'h5d ? rg[k] : a == 12'h5e0 ? {30'h0, stat} :
        a == 12'h5e4 ? {30'h0, mask} : 0;
    bus(w, a, d, r);
    if (!w) chk(r, e);
    if (w && a[11:4] == 8'h5d)
      rg[k] = a[2] ? {d[31:6], 3'h0, d[2] & rg[k][2] & !d[6], d[1:0]} : d;
    if (w && a == 12'h5e0) stat = stat & ~d[1:0];
    if (w && a == 12'h5e4) mask = d[1:0];
    go = a[11:4] == 8'h5d && !rg[ci][1] && !rg[ci][6];
    if (go) begin
      rg[ci][2] = 1'b0;
      chk(g ? {hq, hw, hwd, had} : {lq, lw, lwd, lad}, {1'b1, rg[ci][0], rg[di]});
      if (m == 1) begin
        bus(0, a | 12'h4, 0, r);
        chk(r, {rg[ci][31:6], 3'h1, rg[ci][2:0]});
      end
      if (m == 2) begin
        bus(1, a | 12'h4, 32'h40, r);
        rg[ci] = 32'h40;
      end
      for (n = 0; n < 20 && (g ? hq : lq); n++) begin
        @(posedge sys_clk);
        #1;
      end
      chk(g ? hq : lq, 0);
      @(posedge sys_clk);
      #1;
      if (m != 2) begin
        rg[ci][2] = 1'b1;
        stat[g] = 1'b1;
        if (rg[ci][0]) pm[rg[di][15:0]] = rg[di][31:16];
        else rg[di][31:16] = pm.exists(rg[di][15:0]) ? pm[rg[di][15:0]] : ~rg[di][15:0];
      end
    end
    chk(irq, |(stat & mask));
  endtask : op
  task automatic summarize();
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    for (i = 0; i < 4; i++) op(0, 12'h5d4 ^ i[11:0] << 2, 0, 0);
    op(1, 12'h5e8, rnd(), 0);
    op(0, 12'h5e8, 0, 0);
    for (i = 0; i < 6; i++) begin
      b = i[0] ? 12'h5d8 : 12'h5d0;
      v = rnd();
      op(1, 12'h5e4, {30'h0, v[9:8]}, 0);
      op(1, b + 12'h4, 32'h6, 0);
      op(1, b, rnd(), 0);
      op(0, b, 0, 0);
      lat <= (i % 3) ? 2'h3 : v[1:0];
      op(1, b + 12'h4, {v[31:7], 4'h0, v[2], 2'h1}, i % 3);
      op(1, b + 12'h4, 32'h0, 0);
      op(1, b, rnd(), 0);
      op(1, b + 12'h4, 32'h6, 0);
      op(0, b + 12'h4, 0, 0);
      op(0, b, 0, 0);
      op(1, 12'h5e0, 32'h3, 0);
    end
    summarize();
  end
  initial begin
    #1000000;
    err_count++;
    summarize();
  end
endmodule : phy_config_access_bench
`default_nettype wire
